// [src/fabric_pkg.sv]
// Operation
// - The interrupt input is organised as up to 64 groups of up to 32 request lines each.
// - Every line of a group shares one autovector address and one priority level.
// - DMA drives five lines of group 2, the two timer blocks three lines each of groups 22, 23.
// - Handshake channels: card rx 0, tx 1, audio tx 2, codec 3 to 6, external pins 7 to 10.
// - Each timer channel picks slow osc, bus/4, /8, /16, /32 or one of three external clocks.
// - Every serial transceiver gets a clock enable at bus clock divided by 8.
// - Every SPI unit gets a clock enable at bus clock divided by 32.
// - The NMI and four external interrupt inputs come from port B lines 24 through 28.
// - An enabled trace system owns its trace pins whatever the port function settings say.
// - Trace pin select 0 puts trace on port B lines 0 to 9, select 1 mostly on port C lines.
// - There are five I/O ports, each of up to thirty-two lines.
// - Each I/O line connects to exactly one of two peripheral functions, A or B.
// - An output-only function may sit on several lines and each selected line drives it.
package fabric_pkg;
  // =========================================================
  // sizes
  localparam int NUM_PORTS   = 5;
  localparam int PORT_W      = 32;
  localparam int NUM_GROUPS  = 64;
  localparam int GROUP_LINES = 32;
  localparam int PRIO_W      = 2;
  localparam int VEC_W       = 14;
  localparam int TMR_CH      = 6;
  localparam int TSEL_W      = 3;
  localparam int TRACE_PINS  = 10;
  localparam int HS_NUM      = 11;
  // =========================================================
  // fixed wiring
  localparam int GRP_DMA  = 2;
  localparam int GRP_EXT  = 19;
  localparam int GRP_TMR0 = 22;
  localparam int GRP_TMR1 = 23;
  localparam int HS_CARD_RX  = 0;
  localparam int HS_CARD_TX  = 1;
  localparam int HS_AUDIO_TX = 2;
  localparam int HS_CODEC0   = 3;
  localparam int HS_EXT0     = 7;
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int EXT_IRQ_BASE = 24;
  localparam logic [NUM_PORTS-1:0][PORT_W-1:0] IDLE_LVL = {
    32'h0, 32'h0, 32'h0, 32'h0100_0000, 32'h0};
  // =========================================================
  // clock dividers
  localparam logic [4:0] DIV4_MASK  = 5'h03;
  localparam logic [4:0] DIV8_MASK  = 5'h07;
  localparam logic [4:0] DIV16_MASK = 5'h0f;
  localparam logic [4:0] DIV32_MASK = 5'h1f;
  localparam logic [TSEL_W-1:0] TSEL_SLOW = 3'h0;
  localparam logic [TSEL_W-1:0] TSEL_DIV4 = 3'h1;
  // =========================================================
  // trace pin maps, index 0 frame0 .. 9 data5
  localparam logic [TRACE_PINS-1:0][4:0] TRC_LINE_MAP0 = {
    5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
  localparam logic [TRACE_PINS-1:0][4:0] TRC_LINE_MAP1 = {
    5'h12, 5'h0e, 5'h0c, 5'h0b, 5'h06, 5'h05, 5'h1c, 5'h02, 5'h01, 5'h00};
  localparam logic [TRACE_PINS-1:0] TRC_ON_B1 = 10'h008;
  // =========================================================
  // register map
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_TSEL   = 12'h008;
  localparam logic [11:0] REG_IRQSEL = 12'h00c;
  localparam logic [11:0] REG_FUNC   = 12'h020;
  localparam logic [11:0] REG_GRP    = 12'h100;
  localparam int CTRL_TRC_EN  = 0;
  localparam int CTRL_TRC_SEL = 1;
  localparam int GRP_PRIO_LSB = 0;
  localparam int GRP_VEC_LSB  = 4;
  localparam int IRQSEL_GRP_LSB  = 0;
  localparam int IRQSEL_PRIO_LSB = 8;
  localparam int IRQSEL_VEC_LSB  = 12;
  localparam int IRQSEL_VALID    = 31;
  localparam int STAT_TRC_BIT    = 8;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [PORT_W-1:0] FUNC_RST = 32'h0;
  // =========================================================
  // carriers
  typedef struct packed {
    logic [5:0] data;
    logic       dbg_evt_out_n;
    logic       clock;
    logic [1:0] frame;
  } trace_bus_t;
  typedef struct packed {
    logic              valid;
    logic [5:0]        group;
    logic [PRIO_W-1:0] prio;
    logic [VEC_W-1:0]  vector;
  } irq_sel_t;
endpackage : fabric_pkg

// [src/periph_fabric.sv]
`timescale 1ns/1ps
module periph_fabric
  import fabric_pkg::*;
(
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [11:0]                         paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]    pin_in,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]    pin_out,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]    pin_oe,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]    func_a_out,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]    func_a_oe,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]    func_b_out,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]    func_b_oe,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]    func_a_in,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]    func_b_in,
  input  wire trace_bus_t                          trace,
  input  wire logic [NUM_GROUPS-1:0]               irq_single,
  input  wire logic [4:0]                          dma_irq,
  input  wire logic [2:0]                          tmr0_irq,
  input  wire logic [2:0]                          tmr1_irq,
  input  wire logic [3:0]                          ext_irq_line,
  output logic      [NUM_GROUPS-1:0][GROUP_LINES-1:0] irq_lines,
  output irq_sel_t                                 irq_sel,
  output logic                                     nmi_in_n,
  output logic      [3:0]                          ext_irq_in,
  input  wire logic                                card_rx_req,
  input  wire logic                                card_tx_req,
  input  wire logic                                audio_tx_req,
  input  wire logic [3:0]                          codec_req,
  input  wire logic [3:0]                          ext_dma_req_pin,
  output logic      [HS_NUM-1:0]                   dma_hs_req,
  input  wire logic                                slow_osc_clock,
  input  wire logic [1:0][2:0]                     timer_ext_clock,
  output logic      [TMR_CH-1:0]                   timer_clk_en,
  output logic                                     serial_clk_en,
  output logic                                     spi_clk_en
);

  // =========================================================
  // input synchronisers
  localparam int PIN_N = NUM_PORTS * PORT_W;
  localparam int AW    = PIN_N + 11;
  logic [AW-1:0]                      async_in, s1_reg, s2_reg, s3_reg, filt_reg;
  logic [NUM_PORTS-1:0][PORT_W-1:0]   pin_f;
  logic [3:0]                         dma_pin_f;
  logic [1:0][2:0]                    tmr_ext_f, tmr_ext_prev_reg;
  logic                               osc_f, osc_prev_reg;
  assign async_in  = {slow_osc_clock, timer_ext_clock, ext_dma_req_pin, pin_in};
  assign pin_f     = filt_reg[PIN_N-1:0];
  assign dma_pin_f = filt_reg[PIN_N +: 4];
  assign tmr_ext_f = filt_reg[PIN_N+4 +: 6];
  assign osc_f     = filt_reg[AW-1];
  // level accepted once stages two and three agree; prev copies feed edge detectors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg           <= '0;
      s2_reg           <= '0;
      s3_reg           <= '0;
      filt_reg         <= '0;
      tmr_ext_prev_reg <= '0;
      osc_prev_reg     <= 1'b0;
    end else begin
      s1_reg           <= async_in;
      s2_reg           <= s1_reg;
      s3_reg           <= s2_reg;
      filt_reg         <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
      tmr_ext_prev_reg <= tmr_ext_f;
      osc_prev_reg     <= osc_f;
    end
  end

  // =========================================================
  // clock divider and enables
  function automatic logic div_tick(input logic [4:0] c, input logic [4:0] m);
    return (c & m) == m;
  endfunction : div_tick

  logic [4:0]        div_reg;
  logic [TSEL_W-1:0] tsel_reg [TMR_CH];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_reg <= '0;
    else          div_reg <= div_reg + 5'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_clk_en <= 1'b0;
      spi_clk_en    <= 1'b0;
    end else begin
      serial_clk_en <= div_tick(div_reg, DIV8_MASK);
      spi_clk_en    <= div_tick(div_reg, DIV32_MASK);
    end
  end
  logic [1:0][7:0] tmr_src;
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      tmr_src[b][0]   = osc_f & ~osc_prev_reg;
      tmr_src[b][1]   = div_tick(div_reg, DIV4_MASK);
      tmr_src[b][2]   = div_tick(div_reg, DIV8_MASK);
      tmr_src[b][3]   = div_tick(div_reg, DIV16_MASK);
      tmr_src[b][4]   = div_tick(div_reg, DIV32_MASK);
      tmr_src[b][7:5] = tmr_ext_f[b] & ~tmr_ext_prev_reg[b];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) timer_clk_en <= '0;
    else begin
      for (int c = 0; c < TMR_CH; c++)
        timer_clk_en[c] <= tmr_src[c/3][tsel_reg[c]];
    end
  end

  // =========================================================
  // apb slave
  logic [1:0]              ctrl_reg;
  logic [NUM_PORTS-1:0][PORT_W-1:0] func_reg;
  logic [PRIO_W-1:0]       grp_prio_reg [NUM_GROUPS];
  logic [VEC_W-1:0]        grp_vec_reg  [NUM_GROUPS];
  logic [31:0]             rd_next;
  logic                    hit, is_grp, is_func, acc, wr_fire;
  logic [4:0]              ext_lvl_reg;
  assign acc     = psel & penable;
  assign wr_fire = acc & pready & pwrite;
  assign is_grp  = paddr[11:8] == REG_GRP[11:8];
  assign is_func = (paddr[11:5] == REG_FUNC[11:5]) && (paddr[4:2] < 3'(NUM_PORTS));

  always_comb begin
    rd_next = '0;
    hit     = 1'b1;
    if (is_grp) begin
      rd_next[GRP_PRIO_LSB +: PRIO_W] = grp_prio_reg[paddr[7:2]];
      rd_next[GRP_VEC_LSB +: VEC_W]   = grp_vec_reg[paddr[7:2]];
    end else if (is_func) begin
      rd_next = func_reg[paddr[4:2]];
    end else begin
      unique case (paddr)
        REG_CTRL: rd_next[1:0] = ctrl_reg;
        REG_STATUS: begin
          rd_next[4:0]          = ext_lvl_reg;
          rd_next[STAT_TRC_BIT] = ctrl_reg[CTRL_TRC_EN];
        end
        REG_TSEL: begin
          for (int c = 0; c < TMR_CH; c++)
            rd_next[c*TSEL_W +: TSEL_W] = tsel_reg[c];
        end
        REG_IRQSEL: begin
          rd_next[IRQSEL_GRP_LSB +: 6]       = irq_sel.group;
          rd_next[IRQSEL_PRIO_LSB +: PRIO_W] = irq_sel.prio;
          rd_next[IRQSEL_VEC_LSB +: VEC_W]   = irq_sel.vector;
          rd_next[IRQSEL_VALID]              = irq_sel.valid;
        end
        default: hit = 1'b0;
      endcase
    end
  end

  // one wait state, answer on second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc && !pready && !pwrite && hit) prdata <= rd_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_reg <= CTRL_RST;
    else if (wr_fire && paddr == REG_CTRL) ctrl_reg <= pwdata[1:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < TMR_CH; c++) tsel_reg[c] <= TSEL_SLOW;
    end else if (wr_fire && paddr == REG_TSEL) begin
      for (int c = 0; c < TMR_CH; c++) tsel_reg[c] <= pwdata[c*TSEL_W +: TSEL_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NUM_PORTS; p++) func_reg[p] <= FUNC_RST;
    end else if (wr_fire && is_func) begin
      func_reg[paddr[4:2]] <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        grp_prio_reg[g] <= '0;
        grp_vec_reg[g]  <= '0;
      end
    end else if (wr_fire && is_grp) begin
      grp_prio_reg[paddr[7:2]] <= pwdata[GRP_PRIO_LSB +: PRIO_W];
      grp_vec_reg[paddr[7:2]]  <= pwdata[GRP_VEC_LSB +: VEC_W];
    end
  end

  // =========================================================
  // pin function mux and trace override
  logic [NUM_PORTS-1:0][PORT_W-1:0] out_next, oe_next, own, a_in_next, b_in_next;
  logic [TRACE_PINS-1:0]            trc_vec;
  logic [4:0]                       tl;
  logic                             tb;
  assign trc_vec = trace;
  always_comb begin
    tl  = '0;
    tb  = 1'b0;
    own = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      // per-line A/B choice; duplicated outputs simply appear on every chosen line
      for (int l = 0; l < PORT_W; l++) begin
        out_next[p][l] = func_reg[p][l] ? func_b_out[p][l] : func_a_out[p][l];
        oe_next[p][l]  = func_reg[p][l] ? func_b_oe[p][l]  : func_a_oe[p][l];
      end
    end
    if (ctrl_reg[CTRL_TRC_EN]) begin
      for (int i = 0; i < TRACE_PINS; i++) begin
        tl = ctrl_reg[CTRL_TRC_SEL] ? TRC_LINE_MAP1[i] : TRC_LINE_MAP0[i];
        tb = !ctrl_reg[CTRL_TRC_SEL] || TRC_ON_B1[i];
        if (tb) begin
          out_next[PORT_B][tl] = trc_vec[i];
          oe_next[PORT_B][tl]  = 1'b1;
          own[PORT_B][tl]      = 1'b1;
        end else begin
          out_next[PORT_C][tl] = trc_vec[i];
          oe_next[PORT_C][tl]  = 1'b1;
          own[PORT_C][tl]      = 1'b1;
        end
      end
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int l = 0; l < PORT_W; l++) begin
        a_in_next[p][l] = (!func_reg[p][l] && !own[p][l]) ? pin_f[p][l] : IDLE_LVL[p][l];
        b_in_next[p][l] = (func_reg[p][l] && !own[p][l])  ? pin_f[p][l] : IDLE_LVL[p][l];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out   <= '0;
      pin_oe    <= '0;
      func_a_in <= IDLE_LVL;
      func_b_in <= IDLE_LVL;
    end else begin
      pin_out   <= out_next;
      pin_oe    <= oe_next;
      func_a_in <= a_in_next;
      func_b_in <= b_in_next;
    end
  end

  // nmi and external interrupts are function A of port B lines 24..28
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ext_lvl_reg <= 5'h01;
    else          ext_lvl_reg <= a_in_next[PORT_B][EXT_IRQ_BASE +: 5];
  end

  assign nmi_in_n   = ext_lvl_reg[0];
  assign ext_irq_in = ext_lvl_reg[4:1];

  // =========================================================
  // interrupt groups and handshake channels
  logic [NUM_GROUPS-1:0][GROUP_LINES-1:0] irq_next;
  irq_sel_t                               sel_next;

  always_comb begin
    irq_next = '0;
    for (int g = 0; g < NUM_GROUPS; g++) irq_next[g][0] = irq_single[g];
    irq_next[GRP_DMA][4:0]  = dma_irq;
    irq_next[GRP_TMR0][2:0] = tmr0_irq;
    irq_next[GRP_TMR1][2:0] = tmr1_irq;
    irq_next[GRP_EXT][3:0]  = ext_irq_line;
  end

  // one priority and vector per group, highest priority then lowest group wins
  always_comb begin
    sel_next = '0;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (|irq_lines[g] && (!sel_next.valid || grp_prio_reg[g] > sel_next.prio)) begin
        sel_next.valid  = 1'b1;
        sel_next.group  = 6'(g);
        sel_next.prio   = grp_prio_reg[g];
        sel_next.vector = grp_vec_reg[g];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_lines <= '0;
      irq_sel   <= '0;
    end else begin
      irq_lines <= irq_next;
      irq_sel   <= sel_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dma_hs_req <= '0;
    else begin
      dma_hs_req[HS_CARD_RX]     <= card_rx_req;
      dma_hs_req[HS_CARD_TX]     <= card_tx_req;
      dma_hs_req[HS_AUDIO_TX]    <= audio_tx_req;
      dma_hs_req[HS_CODEC0 +: 4] <= codec_req;
      dma_hs_req[HS_EXT0 +: 4]   <= dma_pin_f;
    end
  end

  // =========================================================
  // assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_hs_map;
    ##1 dma_hs_req[HS_EXT0 +: 4] == $past(dma_pin_f) && dma_hs_req[2] == $past(audio_tx_req);
  endproperty
  a_hs_map : assert property (p_hs_map) else $error("handshake map wrong");
  property p_irq_map;
    ##1 irq_lines[GRP_DMA][4:0] == $past(dma_irq) && irq_lines[GRP_TMR1][2:0] == $past(tmr1_irq);
  endproperty
  a_irq_map : assert property (p_irq_map) else $error("irq group map wrong");
  property p_ser;
    serial_clk_en |=> !serial_clk_en [*7] ##1 serial_clk_en;
  endproperty
  a_ser : assert property (p_ser) else $error("serial enable not div 8");
  property p_spi;
    spi_clk_en |-> ##32 spi_clk_en;
  endproperty
  a_spi : assert property (p_spi) else $error("spi enable not div 32");
  property p_tdiv4;
    timer_clk_en[0] && $past(tsel_reg[0]) == TSEL_DIV4 && tsel_reg[0] == TSEL_DIV4
      ##1 (tsel_reg[0] == TSEL_DIV4) [*3] |=> timer_clk_en[0];
  endproperty
  a_tdiv4 : assert property (p_tdiv4) else $error("timer div4 period wrong");
  property p_trace0;
    $past(ctrl_reg) == 2'h1 |-> pin_oe[PORT_B][9:0] == 10'h3ff;
  endproperty
  a_trace0 : assert property (p_trace0) else $error("trace map 0 not owned");
  property p_trace1;
    $past(ctrl_reg) == 2'h3 |-> pin_oe[PORT_C][18] && pin_out[PORT_B][28] == $past(trc_vec[3]);
  endproperty
  a_trace1 : assert property (p_trace1) else $error("trace map 1 wrong");
  property p_func;
    ##1 pin_out[PORT_A][5] ==
      ($past(func_reg[PORT_A][5]) ? $past(func_b_out[PORT_A][5]) : $past(func_a_out[PORT_A][5]));
  endproperty
  a_func : assert property (p_func) else $error("function select wrong");
  property p_idle;
    $past(func_reg[PORT_B][EXT_IRQ_BASE]) |-> nmi_in_n;
  endproperty
  a_idle : assert property (p_idle) else $error("unassigned input not idle");

endmodule : periph_fabric

// [verif/periph_model.sv]
`timescale 1ns/1ps
module periph_model
  import fabric_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic [31:0] pat,
  output logic      [4:0]  dma_irq,
  output logic      [2:0]  tmr0_irq,
  output logic      [2:0]  tmr1_irq,
  output logic      [3:0]  ext_irq_line,
  output logic             card_rx_req,
  output logic             card_tx_req,
  output logic             audio_tx_req,
  output logic      [3:0]  codec_req
);
  // =========================================================
  // peripheral request levels, launched from the bus clock
  always_ff @(posedge pclk) begin
    {codec_req, audio_tx_req, card_tx_req, card_rx_req, ext_irq_line, tmr1_irq, tmr0_irq,
     dma_irq} <= pat[21:0];
  end
endmodule : periph_model

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
  import fabric_pkg::*;
  // =========================================================
  // signals
  logic                                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                                   slow_osc_clock, nmi_in_n, serial_clk_en, spi_clk_en;
  logic                                   card_rx_req, card_tx_req, audio_tx_req;
  logic [11:0]                            paddr;
  logic [31:0]                            pwdata, prdata, pat, rnd;
  logic [NUM_PORTS-1:0][PORT_W-1:0]       pin_in, pin_out, pin_oe, func_a_in, func_b_in;
  logic [NUM_PORTS-1:0][PORT_W-1:0]       func_a_out, func_a_oe, func_b_out, func_b_oe;
  trace_bus_t                             trace;
  logic [NUM_GROUPS-1:0]                  irq_single;
  logic [NUM_GROUPS-1:0][GROUP_LINES-1:0] irq_lines;
  irq_sel_t                               irq_sel;
  logic [4:0]                             dma_irq;
  logic [2:0]                             tmr0_irq, tmr1_irq;
  logic [3:0]                             ext_irq_line, ext_irq_in, codec_req, ext_dma_req_pin;
  logic [HS_NUM-1:0]                      dma_hs_req;
  logic [1:0][2:0]                        timer_ext_clock;
  logic [TMR_CH-1:0]                      timer_clk_en;
  logic [32:0]                            notes[$];
  int                                     n_fail, tests_run, seed, c_ser, c_spi, c_t0, c_t1, c_t2;

  periph_fabric dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .func_a_out, .func_a_oe, .func_b_out,
    .func_b_oe, .func_a_in, .func_b_in, .trace, .irq_single, .dma_irq, .tmr0_irq, .tmr1_irq,
    .ext_irq_line, .irq_lines, .irq_sel, .nmi_in_n, .ext_irq_in, .card_rx_req, .card_tx_req,
    .audio_tx_req, .codec_req, .ext_dma_req_pin, .dma_hs_req, .slow_osc_clock,
    .timer_ext_clock, .timer_clk_en, .serial_clk_en, .spi_clk_en);
  periph_model peer (.pclk, .pat, .dma_irq, .tmr0_irq, .tmr1_irq, .ext_irq_line,
    .card_rx_req, .card_tx_req, .audio_tx_req, .codec_req);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    slow_osc_clock = 1'b0;
    forever #157 slow_osc_clock = ~slow_osc_clock;
  end
  initial begin
    #400_000;
    n_fail++;
    conclude();
  end

  // =========================================================
  // tasks
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      conclude();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    notes.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  // =========================================================
  // read monitor, oldest note against each completed read
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      chk("pslverr", {31'h0, pslverr}, {31'h0, notes[0][32]});
      if (!notes[0][32]) chk("prdata", prdata, notes[0][31:0]);
      void'(notes.pop_front());
    end
  end

  // =========================================================
  // main sequence
  initial begin
    seed = 78;
    n_fail = 0;
    tests_run = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pat = '0;
    pin_in = '0;
    trace = '0;
    func_a_out = '0;
    func_a_oe = '0;
    func_b_out = '0;
    func_b_oe = '0;
    irq_single = '0;
    ext_dma_req_pin = '0;
    timer_ext_clock = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(REG_CTRL, 32'h0, 1'b0);
    rd(REG_FUNC, 32'h0, 1'b0);
    rd(12'h200, 32'h0, 1'b1);
    wr(REG_GRP + 12'h008, 32'h0001_2343);
    rd(REG_GRP + 12'h008, 32'h0001_2343, 1'b0);
    // random request patterns through the fixed wiring
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      rnd = $random(seed);
      pat <= rnd;
      irq_single <= {rnd, rnd};
      ext_dma_req_pin <= rnd[25:22];
      repeat (6) @(posedge pclk);
      #1;
      chk("grp2", irq_lines[2], {27'h0, rnd[4:0]});
      chk("grp22", irq_lines[22], {29'h0, rnd[7:5]});
      chk("grp23", irq_lines[23], {29'h0, rnd[10:8]});
      chk("grp19", irq_lines[19], {28'h0, rnd[14:11]});
      chk("grp63", irq_lines[63], {31'h0, rnd[31]});
      chk("hs", {21'h0, dma_hs_req}, {21'h0, rnd[25:22], rnd[21:15]});
    end
    // dma lines 0 and 4 of group 2 share one vector and priority
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      irq_single <= '0;
      pat <= (i == 0) ? 32'h1 : 32'h10;
      repeat (4) @(posedge pclk);
      #1;
      chk("irq_sel", 32'(irq_sel), {9'h0, 1'b1, 6'd2, 2'd3, 14'h1234});
    end
    // port lines, external interrupts and idle levels
    @(posedge pclk);
    rnd = $random(seed);
    pin_in <= {5{rnd}};
    func_a_out <= {5{rnd}};
    func_b_out <= {5{~rnd}};
    func_a_oe <= {5{rnd ^ 32'h5a5a_5a5a}};
    func_b_oe <= {5{~rnd}};
    repeat (6) @(posedge pclk);
    #1;
    chk("nmi", {31'h0, nmi_in_n}, {31'h0, rnd[24]});
    chk("ext_irq", {28'h0, ext_irq_in}, {28'h0, rnd[28:25]});
    chk("a_in_b", func_a_in[1], rnd);
    chk("b_in_b", func_b_in[1], IDLE_LVL[1]);
    chk("out_a", pin_out[0], rnd);
    chk("oe_a", pin_oe[0], rnd ^ 32'h5a5a_5a5a);
    wr(REG_FUNC, 32'hffff_ffff);
    repeat (6) @(posedge pclk);
    #1;
    chk("out_b", pin_out[0], ~rnd);
    chk("a_in_idle", func_a_in[0], IDLE_LVL[0]);
    chk("b_in_a", func_b_in[0], rnd);
    // trace takeover in both pin maps
    @(posedge pclk);
    trace <= trace_bus_t'(rnd[9:0]);
    wr(REG_FUNC + 12'h004, 32'hffff_ffff);
    wr(REG_CTRL, 32'h1);
    #1;
    chk("trc0", {22'h0, pin_out[1][9:0]}, {22'h0, rnd[9:0]});
    chk("trc0_oe", {22'h0, pin_oe[1][9:0]}, 32'h3ff);
    @(posedge pclk);
    wr(REG_CTRL, 32'h3);
    #1;
    chk("trc1", {29'h0, pin_out[2][18], pin_out[1][28], pin_out[2][0]},
        {29'h0, rnd[9], rnd[3], rnd[0]});
    // divided clock enables
    @(posedge pclk);
    wr(REG_TSEL, 32'h161);
    c_ser = 0;
    c_spi = 0;
    c_t0 = 0;
    c_t1 = 0;
    c_t2 = 0;
    for (int j = 0; j < 64; j++) begin
      @(posedge pclk);
      if (j % 4 == 0) timer_ext_clock[0][0] <= ~timer_ext_clock[0][0];
      #1;
      c_ser += serial_clk_en;
      c_spi += spi_clk_en;
      c_t0 += timer_clk_en[0];
      c_t1 += timer_clk_en[1];
      c_t2 += timer_clk_en[2];
    end
    chk("serial", c_ser, 32'd8);
    chk("spi", c_spi, 32'd2);
    chk("tmr_div4", c_t0, 32'd16);
    chk("tmr_div32", c_t1, 32'd2);
    chk("tmr_ext", c_t2, 32'd8);
    conclude();
  end
endmodule : tb
